// *** inc/cad_params.svh ***
// timing, width and encoding constants for the core alu datapath
`ifndef CAD_PARAMS_SVH
`define CAD_PARAMS_SVH
`define CAD_IW          14
`define CAD_DW          8
`define CAD_PCW         11
`define CAD_FAW         7
`define CAD_PC_RST      11'h000
`define CAD_W_RST       8'h00
`define CAD_NOP_WORD    14'h0000
`define CAD_PCL_ADDR    7'h02
`define CAD_STAT_ADDR   7'h03
`define CAD_FSR_ADDR    7'h04
`define CAD_IND_ADDR    7'h00
`define CAD_FLAG_C      0
`define CAD_FLAG_DC     1
`define CAD_FLAG_Z      2
`define CAD_NIB_LO      3
`define CAD_NIB_HI      4
`define CAD_CLK_NS      10
`endif

// *** inc/cad_pkg.sv ***
// types shared by the core alu datapath
package cad_pkg;
	typedef enum logic [4:0]
	{
		CAD_OP_ADD = 5'h00,
		CAD_OP_SUB = 5'h01,
		CAD_OP_AND = 5'h02,
		CAD_OP_IOR = 5'h03,
		CAD_OP_XOR = 5'h04,
		CAD_OP_COM = 5'h05,
		CAD_OP_INC = 5'h06,
		CAD_OP_DEC = 5'h07,
		CAD_OP_RLF = 5'h08,
		CAD_OP_RRF = 5'h09,
		CAD_OP_SWP = 5'h0a,
		CAD_OP_MOV = 5'h0b,
		CAD_OP_CLR = 5'h0c,
		CAD_OP_PSB = 5'h0d
	} cad_aluop_type;

	typedef struct packed
	{
		logic       c;
		logic       nibble_out_bit;
		logic       z;
	} cad_flags_type;

	typedef struct packed
	{
		logic [7:0]    res;
		cad_flags_type flg;
	} cad_alu_out_type;

	typedef enum logic [2:0]
	{
		CAD_ST_RUN   = 3'b001,
		CAD_ST_FLUSH = 3'b010,
		CAD_ST_SKIP  = 3'b100
	} cad_state_type;
endpackage

// *** hw/cad_alu.sv ***
// 8-bit alu: add, subtract, shifts, boolean, flag generation
`timescale 1ns/1ps
`include "cad_params.svh"
module cad_alu
	import cad_pkg::*;
(
	// operands
	input  wire logic [`CAD_DW-1:0] a,
	input  wire logic [`CAD_DW-1:0] b,
	input  wire logic               c_in,
	input  wire cad_aluop_type      op,
	// result
	output cad_alu_out_type         y
);
	logic [`CAD_DW:0]   sum;
	logic [`CAD_NIB_HI:0] nib;
	logic [`CAD_DW-1:0] r;
	logic               co;
	logic               dco;

	always_comb
	begin
		sum = {1'b0, b} + {1'b0, a};
		nib = {1'b0, b[`CAD_NIB_LO:0]} + {1'b0, a[`CAD_NIB_LO:0]};
		r   = sum[`CAD_DW-1:0];
		co  = sum[`CAD_DW];
		dco = nib[`CAD_NIB_HI];
		case (op)
			CAD_OP_ADD: ;
			CAD_OP_SUB, CAD_OP_PSB:
			begin
				// b minus a as b plus two's complement of a; carry high means no borrow
				sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
				nib = {1'b0, b[`CAD_NIB_LO:0]} + {1'b0, ~a[`CAD_NIB_LO:0]} + 5'h01;
				r   = sum[`CAD_DW-1:0];
				co  = sum[`CAD_DW];
				dco = nib[`CAD_NIB_HI];
			end
			CAD_OP_AND: r = a & b;
			CAD_OP_IOR: r = a | b;
			CAD_OP_XOR: r = a ^ b;
			CAD_OP_COM: r = ~b;
			CAD_OP_INC: r = b + 8'h01;
			CAD_OP_DEC: r = b - 8'h01;
			CAD_OP_RLF:
			begin
				r  = {b[`CAD_DW-2:0], c_in};
				co = b[`CAD_DW-1];
			end
			CAD_OP_RRF:
			begin
				r  = {c_in, b[`CAD_DW-1:1]};
				co = b[0];
			end
			CAD_OP_SWP: r = {b[`CAD_NIB_LO:0], b[`CAD_DW-1:`CAD_NIB_HI]};
			CAD_OP_MOV: r = b;
			CAD_OP_CLR: r = 8'h00;
			default:    r = b;
		endcase
		y.res                = r;
		y.flg.c              = co;
		y.flg.nibble_out_bit = dco;
		y.flg.z              = (r == 8'h00);
	end
endmodule

// *** hw/cad_core.sv ***
// two-stage fetch/execute core datapath with accumulator and flags
// Behaviour
// - every instruction is a single 14-bit word
// - program fetch bus is 14 bits, one word per cycle
// - next word is fetched while the current one executes
// - one cycle per instruction; flow changes flush the prefetched word
// - separate program and data buses, both used in the same cycle
// - special registers incl. program counter live in data space, direct or indirect
// - every operation works on any file register in any addressing mode
// - 8-bit alu does add, subtract, shifts and boolean logic
// - arithmetic is two's complement
// - two-operand ops take accumulator plus file register or literal
// - single-operand ops act on accumulator or one file register
// - 8-bit accumulator is not mapped in data memory
// - alu updates carry, nibble carry and zero flags per instruction
// - subtraction uses carry as borrow and nibble carry as nibble borrow
// - counter covers 512, 1k or 2k words of internal program memory
`timescale 1ns/1ps
`include "cad_params.svh"
module cad_core
	import cad_pkg::*;
#(
	parameter logic [`CAD_PCW-1:0] PM_WORDS_M1 = 11'h1ff
)
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// program memory bus
	output logic [`CAD_PCW-1:0]      pm_addr_ff,
	input  wire logic [`CAD_IW-1:0]  pm_data,
	// data memory bus
	output logic [`CAD_FAW-1:0]      dm_addr_ff,
	output logic [`CAD_DW-1:0]       dm_wdata_ff,
	output logic                     dm_we_ff,
	input  wire logic [`CAD_DW-1:0]  dm_rdata,
	output logic [`CAD_FAW-1:0]      dm_raddr_ff,
	// observed state
	output logic [`CAD_DW-1:0]       acc_ff,
	output cad_flags_type            flags_ff
);
	logic            rs1_ff;
	logic            rs2_ff;
	logic [`CAD_PCW-1:0] pc_ff;
	logic [`CAD_PCW-1:0] nxt_pc;
	logic [`CAD_IW-1:0]  ir_ff;
	logic [`CAD_IW-1:0]  nxt_ir;
	logic [`CAD_DW-1:0]  fsr_ff;
	logic [`CAD_DW-1:0]  nxt_fsr;
	logic [`CAD_DW-1:0]  nxt_acc;
	cad_flags_type       nxt_flags;
	cad_state_type       st_ff;
	cad_state_type       nxt_st;
	logic [`CAD_FAW-1:0] nxt_dm_addr;
	logic [`CAD_DW-1:0]  nxt_dm_wdata;
	logic                nxt_dm_we;
	logic [`CAD_PCW-1:0] nxt_pm_addr;
	logic [`CAD_FAW-1:0] fa;
	logic [`CAD_FAW-1:0] ea;
	logic [`CAD_DW-1:0]  fval;
	logic [`CAD_DW-1:0]  lit;
	logic [`CAD_DW-1:0]  a_op;
	logic [`CAD_DW-1:0]  b_op;
	logic                dest_f;
	logic                upd_c;
	logic                upd_dc;
	logic                upd_z;
	logic                wr_res;
	logic                flush;
	logic                skip;
	logic                skip_z;
	logic [`CAD_FAW-1:0] nxt_dm_raddr;
	cad_aluop_type       op;
	cad_alu_out_type     y;

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_ff <= 1'b0;
			rs2_ff <= 1'b0;
		end
		else
		begin
			rs1_ff <= 1'b1;
			rs2_ff <= rs1_ff;
		end
	end

	assign fa       = ir_ff[`CAD_FAW-1:0];
	assign ea       = (fa == `CAD_IND_ADDR) ? fsr_ff[`CAD_FAW-1:0] : fa;
	assign lit      = ir_ff[`CAD_DW-1:0];
	assign dest_f   = ir_ff[`CAD_FAW];

	// special registers are read from inside the core, the rest from data memory
	always_comb
	begin
		case (ea)
			`CAD_PCL_ADDR:  fval = pc_ff[`CAD_DW-1:0];
			`CAD_STAT_ADDR: fval = {5'h00, flags_ff.z, flags_ff.nibble_out_bit, flags_ff.c};
			`CAD_FSR_ADDR:  fval = fsr_ff;
			// a file stored by the previous instruction has not reached memory yet
			default:        fval = (dm_we_ff && dm_addr_ff == ea) ? dm_wdata_ff : dm_rdata;
		endcase
	end

	cad_alu u_alu
	(
		.a    (a_op),
		.b    (b_op),
		.c_in (flags_ff.c),
		.op   (op),
		.y    (y)
	);

	// decode: 00 byte ops on file, 01 bit ops, 10 goto, 11 literal ops
	always_comb
	begin
		op     = CAD_OP_MOV;
		a_op   = acc_ff;
		b_op   = fval;
		upd_c  = 1'b0;
		upd_dc = 1'b0;
		upd_z  = 1'b0;
		wr_res = 1'b0;
		flush  = 1'b0;
		skip   = 1'b0;
		skip_z = 1'b0;
		nxt_pm_addr = pc_ff;
		case (ir_ff[13:12])
			2'b00:
			begin
				wr_res = 1'b1;
				case (ir_ff[11:8])
					// store of the accumulator into the file
					4'h0: begin wr_res = dest_f; b_op = acc_ff; end
					4'h1: begin op = CAD_OP_CLR; upd_z = 1'b1; end
					4'h2: begin op = CAD_OP_SUB; {upd_c, upd_dc, upd_z} = 3'b111; end
					4'h3: begin op = CAD_OP_DEC; upd_z = 1'b1; end
					4'h4: begin op = CAD_OP_IOR; upd_z = 1'b1; end
					4'h5: begin op = CAD_OP_AND; upd_z = 1'b1; end
					4'h6: begin op = CAD_OP_XOR; upd_z = 1'b1; end
					4'h7: begin op = CAD_OP_ADD; {upd_c, upd_dc, upd_z} = 3'b111; end
					4'h8: begin op = CAD_OP_MOV; upd_z = 1'b1; end
					4'h9: begin op = CAD_OP_COM; upd_z = 1'b1; end
					4'ha: begin op = CAD_OP_INC; upd_z = 1'b1; end
					4'hb: begin op = CAD_OP_DEC; skip_z = 1'b1; end
					4'hc: begin op = CAD_OP_RRF; upd_c = 1'b1; end
					4'hd: begin op = CAD_OP_RLF; upd_c = 1'b1; end
					4'he: op = CAD_OP_SWP;
					4'hf: begin op = CAD_OP_INC; skip_z = 1'b1; end
					default: wr_res = 1'b0;
				endcase
			end
			2'b01:
			begin
				// bit clear/set rewrite the file; bit tests may skip
				case (ir_ff[11:10])
					2'b00: b_op = fval & ~(8'h01 << ir_ff[9:7]);
					2'b01: b_op = fval | (8'h01 << ir_ff[9:7]);
					2'b10: skip = ~fval[ir_ff[9:7]];
					default: skip = fval[ir_ff[9:7]];
				endcase
				wr_res = ~ir_ff[11];
			end
			2'b10:
			begin
				flush = 1'b1;
				nxt_pm_addr = ir_ff[`CAD_PCW-1:0] & PM_WORDS_M1;
			end
			default:
			begin
				b_op = lit;
				case (ir_ff[11:8])
					4'h8: begin op = CAD_OP_IOR; upd_z = 1'b1; end
					4'h9: begin op = CAD_OP_AND; upd_z = 1'b1; end
					4'ha: begin op = CAD_OP_XOR; upd_z = 1'b1; end
					4'hc, 4'hd: begin op = CAD_OP_PSB; {upd_c, upd_dc, upd_z} = 3'b111; end
					4'he, 4'hf: begin op = CAD_OP_ADD; {upd_c, upd_dc, upd_z} = 3'b111; end
					default: op = CAD_OP_MOV;
				endcase
			end
		endcase
	end

	// execute and fetch in the same cycle
	always_comb
	begin
		nxt_acc      = acc_ff;
		nxt_flags    = flags_ff;
		nxt_fsr      = fsr_ff;
		nxt_dm_addr  = ea;
		nxt_dm_wdata = y.res;
		nxt_dm_we    = 1'b0;
		nxt_st       = CAD_ST_RUN;
		nxt_pc       = (pc_ff + 11'h001) & PM_WORDS_M1;
		nxt_ir       = pm_data;
		case (st_ff)
			CAD_ST_RUN:
			begin
				if (upd_c)
					nxt_flags.c = y.flg.c;
				if (upd_dc)
					nxt_flags.nibble_out_bit = y.flg.nibble_out_bit;
				if (upd_z)
					nxt_flags.z = y.flg.z;
				if (ir_ff[13:12] == 2'b11)
					nxt_acc = y.res;
				else if (wr_res && !dest_f && ir_ff[13:12] == 2'b00)
					nxt_acc = y.res;
				else if (wr_res)
				begin
					nxt_dm_we = 1'b1;
					if (ea == `CAD_FSR_ADDR)
						nxt_fsr = y.res;
					else if (ea == `CAD_STAT_ADDR)
						{nxt_flags.z, nxt_flags.nibble_out_bit, nxt_flags.c} = y.res[2:0];
					else if (ea == `CAD_PCL_ADDR)
					begin
						nxt_pc = {pc_ff[`CAD_PCW-1:`CAD_DW], y.res} & PM_WORDS_M1;
						nxt_st = CAD_ST_FLUSH;
					end
				end
				if (flush)
				begin
					nxt_pc = nxt_pm_addr;
					nxt_st = CAD_ST_FLUSH;
				end
				else if (skip || (skip_z && y.res == 8'h00))
					nxt_st = CAD_ST_SKIP;
				if (nxt_st != CAD_ST_RUN)
					nxt_ir = `CAD_NOP_WORD;
			end
			default: ; // discarded word executes as a no-op
		endcase
		// read address leaves from a flop; it tracks the word about to execute
		nxt_dm_raddr = (nxt_ir[`CAD_FAW-1:0] == `CAD_IND_ADDR) ? nxt_fsr[`CAD_FAW-1:0]
			: nxt_ir[`CAD_FAW-1:0];
	end

	always_ff @(posedge clk or negedge rs2_ff)
	begin
		if (!rs2_ff)
		begin
			pc_ff       <= `CAD_PC_RST;
			pm_addr_ff  <= `CAD_PC_RST;
			ir_ff       <= `CAD_NOP_WORD;
			acc_ff      <= `CAD_W_RST;
			flags_ff    <= '0;
			fsr_ff      <= 8'h00;
			st_ff       <= CAD_ST_RUN;
			dm_addr_ff  <= 7'h00;
			dm_wdata_ff <= 8'h00;
			dm_we_ff    <= 1'b0;
			dm_raddr_ff <= 7'h00;
		end
		else
		begin
			pc_ff       <= nxt_pc;
			pm_addr_ff  <= nxt_pc;
			ir_ff       <= nxt_ir;
			acc_ff      <= nxt_acc;
			flags_ff    <= nxt_flags;
			fsr_ff      <= nxt_fsr;
			st_ff       <= nxt_st;
			dm_addr_ff  <= nxt_dm_addr;
			dm_wdata_ff <= nxt_dm_wdata;
			dm_we_ff    <= nxt_dm_we;
			dm_raddr_ff <= nxt_dm_raddr;
		end
	end
endmodule

// *** verification/cad_core_monitor.sv ***
// assertion checker on the core datapath ports
`timescale 1ns/1ps
module cad_core_monitor
	import cad_pkg::*;
#(
	parameter logic [10:0] PM_WORDS_M1 = 11'h1ff
)
(
	// clock and reset
	input wire logic          clk,
	input wire logic          rst_n,
	// buses
	input wire logic [10:0]   pm_addr_ff,
	input wire logic [13:0]   pm_data,
	input wire logic [6:0]    dm_addr_ff,
	input wire logic [7:0]    dm_wdata_ff,
	input wire logic          dm_we_ff,
	// state
	input wire logic [7:0]    acc_ff,
	input wire cad_flags_type flags_ff
);
	logic [13:0] w1_ff, w2_ff, w3_ff;
	logic [7:0]  a1_ff;
	logic [3:0]  n_ff;
	// w2 is the word whose result shows now; w3 a jump means it was flushed
	wire         ok = n_ff[3] && w3_ff[13:12] != 2'b10;
	always_ff @(posedge clk)
	begin
		w1_ff <= pm_data;
		w2_ff <= w1_ff;
		w3_ff <= w2_ff;
		a1_ff <= acc_ff;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			n_ff <= 4'h0;
		else if (!n_ff[3])
			n_ff <= n_ff + 4'h1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_step;
		n_ff[3] && w2_ff[13:12] != 2'b10
			|-> pm_addr_ff == (($past(pm_addr_ff) + 11'h1) & PM_WORDS_M1);
	endproperty
	a_step: assert property (p_step) else $error("fetch did not step");
	property p_jump;
		ok && w2_ff[13:12] == 2'b10 |-> pm_addr_ff == (w2_ff[10:0] & PM_WORDS_M1);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");
	property p_wr;
		ok && w2_ff[13:7] == 7'h01
			|-> dm_we_ff && dm_addr_ff == w2_ff[6:0] && dm_wdata_ff == acc_ff;
	endproperty
	a_wr: assert property (p_wr) else $error("store wrong");
	property p_add;
		ok && w2_ff[13:9] == 5'h1f
			|-> {flags_ff.c, acc_ff} == {1'b0, a1_ff} + {1'b0, w2_ff[7:0]};
	endproperty
	a_add: assert property (p_add) else $error("add wrong");
	property p_sub;
		ok && w2_ff[13:9] == 5'h1e |-> acc_ff == w2_ff[7:0] - a1_ff
			&& flags_ff.c == (w2_ff[7:0] >= a1_ff)
			&& flags_ff.nibble_out_bit == (w2_ff[3:0] >= a1_ff[3:0]);
	endproperty
	a_sub: assert property (p_sub) else $error("subtract wrong");
	property p_zero;
		ok && w2_ff[13:11] == 3'h7 |-> flags_ff.z == (acc_ff == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_movl;
		ok && w2_ff[13:10] == 4'hc |-> acc_ff == w2_ff[7:0] && $stable(flags_ff);
	endproperty
	a_movl: assert property (p_movl) else $error("literal load wrong");
	property p_range;
		pm_addr_ff <= PM_WORDS_M1;
	endproperty
	a_range: assert property (p_range) else $error("pc out of range");
endmodule
bind cad_core cad_core_monitor #(.PM_WORDS_M1(PM_WORDS_M1)) u_mon
(
	.clk         (clk),
	.rst_n       (rst_n),
	.pm_addr_ff  (pm_addr_ff),
	.pm_data     (pm_data),
	.dm_addr_ff  (dm_addr_ff),
	.dm_wdata_ff (dm_wdata_ff),
	.dm_we_ff    (dm_we_ff),
	.acc_ff      (acc_ff),
	.flags_ff    (flags_ff)
);

// *** verification/cad_mem_model.sv ***
// program and data memory model facing the core
`timescale 1ns/1ps
module cad_mem_model
(
	// clock
	input wire logic        clk,
	// program side
	input wire logic [10:0] pm_addr_ff,
	output logic [13:0]     pm_data,
	// data side
	input wire logic [6:0]  dm_raddr_ff,
	input wire logic [6:0]  dm_addr_ff,
	input wire logic [7:0]  dm_wdata_ff,
	input wire logic        dm_we_ff,
	output logic [7:0]      dm_rdata
);
	logic [13:0] pm [0:2047];
	logic [7:0]  dm [0:127];
	assign pm_data = pm[pm_addr_ff];
	assign dm_rdata = dm[dm_raddr_ff];
	always_ff @(posedge clk)
	begin
		if (dm_we_ff)
			dm[dm_addr_ff] <= dm_wdata_ff;
	end
endmodule

// *** verification/test_cad_core.sv ***
// self-checking bench: a program runs from the memory model
`timescale 1ns/1ps
module test_cad_core;
	import cad_pkg::*;
	logic          clk;
	logic          rst_n;
	logic [10:0]   pm_addr_ff;
	logic [13:0]   pm_data;
	logic [6:0]    dm_addr_ff, dm_raddr_ff;
	logic [7:0]    dm_wdata_ff, dm_rdata, acc_ff, r;
	logic          dm_we_ff, c, d, z;
	cad_flags_type flags_ff;
	logic [14:0]   exp_q[$];
	int            fail_count, checked, pc;
	cad_core uut (.clk, .rst_n, .pm_addr_ff, .pm_data, .dm_addr_ff, .dm_wdata_ff,
		.dm_we_ff, .dm_rdata, .dm_raddr_ff, .acc_ff, .flags_ff);
	cad_mem_model mem (.clk, .pm_addr_ff, .pm_data, .dm_raddr_ff, .dm_addr_ff,
		.dm_wdata_ff, .dm_we_ff, .dm_rdata);
	task put(input logic [13:0] w);
		mem.pm[pc] = w;
		pc++;
	endtask
	// store the model accumulator and note the write it must cause
	task st(input logic [6:0] f);
		put({7'h01, f});
		exp_q.push_back({f, r});
	endtask
	task add3(input logic [7:0] x, input logic [7:0] y, input logic ci);
		logic [4:0] n;
		{c, r} = {1'b0, x} + {1'b0, y} + {8'h00, ci};
		n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
		d = n[4];
		z = r == 8'h00;
	endtask
	task chk(input logic [14:0] seen);
		logic [14:0] e;
		e = exp_q.size() != 0 ? exp_q.pop_front() : 15'bx;
		checked++;
		if (seen !== e)
		begin
			fail_count++;
			$display("MISMATCH dm write exp %h seen %h", e, seen);
		end
	endtask
	task give_verdict;
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (dm_we_ff === 1'b1)
			chk({dm_addr_ff, dm_wdata_ff});
	initial
	begin
		#20000;
		fail_count++;
		$display("MISMATCH watchdog exp done seen hang");
		give_verdict;
	end
	initial
	begin
		logic [7:0] a, b, v;
		logic [5:0] opc [5];
		opc = '{6'h3e, 6'h3c, 6'h39, 6'h38, 6'h3a};
		{fail_count, checked, pc} = '0;
		{c, d, z} = 3'h0;
		rst_n = 1'b0;
		void'($urandom(32'h024c));
		for (int i = 0; i < 2048; i++)
			mem.pm[i] = 14'h0000;
		for (int i = 0; i < 10; i++)
		begin
			a = 8'($urandom());
			b = 8'($urandom());
			put({6'h30, a});
			put({opc[i % 5], b});
			case (i % 5)
				0: add3(a, b, 1'b0);
				1: add3(~a, b, 1'b1);
				2: r = a & b;
				3: r = a | b;
				default: r = a ^ b;
			endcase
			z = r == 8'h00;
			v = r;
			st(7'h20);
			// flags read back as a file, then added to the stored byte
			put(14'h0803);
			r = {5'h00, z, d, c};
			z = r == 8'h00;
			st(7'h21);
			put(14'h0720);
			add3(r, v, 1'b0);
			st(7'h22);
		end
		// the word after a jump must never store
		put(14'h2800 | 14'(pc + 2));
		put(14'h00a4);
		r = 8'($urandom());
		put({6'h30, r});
		st(7'h25);
		put(14'h2800 | 14'(pc));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 500 && exp_q.size() > 0; k++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		if (exp_q.size() != 0)
			chk(15'h7fff);
		give_verdict;
	end
endmodule
